// File: bgr_pkg.sv
// shared constants and types for the blit geometry register group
// assumes one host register clock; offsets are the printed 16-bit ones
package bgr_pkg;

   localparam logic [15:0] OFS_PAT_LO = 16'h1820;
   localparam logic [15:0] OFS_PAT_HI = 16'h1822;
   localparam logic [15:0] OFS_LINE_OFS = 16'h1824;
   localparam logic [15:0] OFS_WIDTH = 16'h1826;
   localparam logic [15:0] OFS_HEIGHT = 16'h1828;
   localparam logic [15:0] OFS_STATUS = 16'h1830;
   localparam logic [15:0] OFS_CLIP_X = 16'h1834;

   localparam int PAT_ADDR_W = 27;
   localparam int PAT_HI_W = 11;
   localparam int LINE_OFS_W = 13;
   localparam int DIM_W = 11;
   localparam int POS_W = 12;
   localparam int CLIP_Y_W = 10;
   localparam int STATUS_W = 6;

   localparam logic [15:0] RST_PAT_LO = 16'h0000;
   localparam logic [PAT_HI_W-1:0] RST_PAT_HI = 11'h000;
   localparam logic [LINE_OFS_W-1:0] RST_LINE_OFS = 13'h0000;
   localparam logic [DIM_W-1:0] RST_WIDTH = 11'h001;
   localparam logic [DIM_W-1:0] RST_HEIGHT = 11'h001;
   localparam logic [DIM_W-1:0] RST_CLIP_X = 11'h000;
   localparam logic [DIM_W-1:0] DIM_ZERO = 11'h000;
   localparam logic [DIM_W-1:0] DIM_ONE = 11'h001;

   localparam logic [DIM_W-1:0] MAX_WIDTH = 11'h500;
   localparam logic [DIM_W-1:0] MAX_HEIGHT = 11'h400;
   localparam logic [DIM_W-1:0] MIN_EXPAND_WIDTH = 11'h008;

   localparam logic [2:0] OP_PATTERN_FILL_TRANSP = 3'h4;
   localparam logic [2:0] OP_MOVE = 3'h2;
   localparam logic [1:0] AREA_RECT = 2'h0;

   // status bit positions
   localparam int ST_WIDTH_RANGE = 0;
   localparam int ST_HEIGHT_RANGE = 1;
   localparam int ST_ODD_8BPP = 2;
   localparam int ST_EXPAND_MIN = 3;
   localparam int ST_PAT_ACTIVE = 4;
   localparam int ST_ROP_ACTIVE = 5;

   typedef enum logic [1:0] {
      BGR_BPP8,
      BGR_BPP16,
      BGR_BPP32
   } bgr_depth_e;

   typedef struct packed {
      logic [2:0] operation_select_field;
      logic raster_op_enable;
      logic colour_expand_select;
      logic [1:0] area_type_mode;
      bgr_depth_e depth;
   } bgr_ctrl_s;

   typedef struct packed {
      logic [PAT_ADDR_W-1:0] base;
      logic [2:0] line_ofs;
      logic [4:0] pix_ofs;
   } bgr_pattern_s;

   // log2 of bytes per pixel; the unused code is treated as 32 bpp
   function automatic logic [1:0] bgr_bpp_shift(input bgr_depth_e d);
      logic [1:0] s;
      s = 2'h2;
      case (d)
         BGR_BPP8: s = 2'h0;
         BGR_BPP16: s = 2'h1;
         default: s = 2'h2;
      endcase
      return s;
   endfunction

endpackage

// File: bgr_pattern_split.sv
// splits the pattern start address by colour depth
// assumes inputs come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module bgr_pattern_split
   import bgr_pkg::*;
(
   input wire logic clock,
   input wire logic ce,
   input wire logic sys_rst,
   input wire logic [PAT_ADDR_W-1:0] start_addr,
   input wire bgr_ctrl_s ctrl,
   output bgr_pattern_s pattern,
   output logic pattern_valid,
   output logic [PAT_ADDR_W-1:0] rop_pattern_addr,
   output logic rop_pattern_valid
);

   bgr_pattern_s split_nxt;

   always_comb begin
      split_nxt = '0;
      unique case (ctrl.depth)
         BGR_BPP8: begin
            split_nxt.base = {start_addr[26:7], 7'h00};
            split_nxt.line_ofs = start_addr[5:3];
            split_nxt.pix_ofs = {2'h0, start_addr[2:0]};
         end
         BGR_BPP16: begin
            split_nxt.base = {start_addr[26:8], 8'h00};
            split_nxt.line_ofs = start_addr[6:4];
            split_nxt.pix_ofs = {1'b0, start_addr[3:1], 1'b0};
         end
         default: begin
            split_nxt.base = {start_addr[26:9], 9'h000};
            split_nxt.line_ofs = start_addr[7:5];
            split_nxt.pix_ofs = {start_addr[4:2], 2'h0};
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pattern <= '0;
         pattern_valid <= 1'b0;
      end else if (ce) begin
         pattern <= split_nxt;
         pattern_valid <=
            (ctrl.operation_select_field == OP_PATTERN_FILL_TRANSP);
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rop_pattern_addr <= '0;
         rop_pattern_valid <= 1'b0;
      end else if (ce) begin
         rop_pattern_addr <= start_addr;
         rop_pattern_valid <= ctrl.raster_op_enable;
      end
   end

endmodule
`default_nettype wire

// File: bgr_window_addr.sv
// window start address: base + x * bytes per pixel + y * line offset
// assumes inputs come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module bgr_window_addr
   import bgr_pkg::*;
(
   input wire logic clock,
   input wire logic ce,
   input wire logic sys_rst,
   input wire logic [PAT_ADDR_W-1:0] base,
   input wire logic [POS_W-1:0] pos_x,
   input wire logic [POS_W-1:0] pos_y,
   input wire logic [LINE_OFS_W-1:0] line_ofs,
   input wire bgr_depth_e depth,
   output logic [PAT_ADDR_W-1:0] start_addr
);

   logic signed [27:0] x_ext;
   logic signed [27:0] x_term;
   logic signed [26:0] y_prod;
   logic signed [27:0] sum;

   // positions are two's complement; result wraps modulo the address space
   always_comb begin
      x_ext = 28'(signed'(pos_x));
      x_term = x_ext <<< bgr_bpp_shift(depth);
      // both operands widened first so the product is never cut short
      y_prod = 27'(signed'(pos_y)) * 27'(signed'({1'b0, line_ofs}));
      sum = signed'({1'b0, base}) + x_term + 28'(y_prod);
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         start_addr <= '0;
      end else if (ce) begin
         start_addr <= sum[PAT_ADDR_W-1:0];
      end
   end

endmodule
`default_nettype wire

// File: bgr_regs.sv
// blit geometry register group: pattern start, line offset, size, clip x
// assumes a same-clock host port and a same-clock address generator
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module bgr_regs
   import bgr_pkg::*;
(
   input wire logic clock,
   input wire logic ce,
   input wire logic sys_rst,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire bgr_ctrl_s ctrl,
   input wire logic [PAT_ADDR_W-1:0] src_base,
   input wire logic [POS_W-1:0] src_x,
   input wire logic [POS_W-1:0] src_y,
   input wire logic [PAT_ADDR_W-1:0] dst_base,
   input wire logic [POS_W-1:0] dst_x,
   input wire logic [POS_W-1:0] dst_y,
   input wire logic [CLIP_Y_W-1:0] clip_y,
   output bgr_pattern_s pattern,
   output logic pattern_valid,
   output logic [PAT_ADDR_W-1:0] rop_pattern_addr,
   output logic rop_pattern_valid,
   output logic [LINE_OFS_W-1:0] eff_line_offset,
   output logic [DIM_W-1:0] op_width,
   output logic [DIM_W-1:0] op_height,
   output logic [DIM_W-1:0] clip_x_start,
   output logic [PAT_ADDR_W-1:0] src_start_addr,
   output logic [PAT_ADDR_W-1:0] dst_start_addr,
   output logic [PAT_ADDR_W-1:0] clip_start_addr,
   output logic [STATUS_W-1:0] param_status
);

   logic [15:0] pat_lo_r;
   logic [PAT_HI_W-1:0] pat_hi_r;
   logic [LINE_OFS_W-1:0] line_ofs_r;
   logic [DIM_W-1:0] width_r;
   logic [DIM_W-1:0] height_r;
   logic [DIM_W-1:0] clip_x_r;
   logic [STATUS_W-1:0] status_r;
   logic [STATUS_W-1:0] status_nxt;
   logic [LINE_OFS_W-1:0] eff_ofs_r;
   logic [15:0] rdata_nxt;
   logic [PAT_ADDR_W-1:0] pat_start;
   logic [DIM_W-1:0] wr_dim;
   logic [DIM_W-1:0] wr_dim_fixed;

   assign pat_start = {pat_hi_r, pat_lo_r};

   // the field part of the write; a zero size is forced to one
   always_comb begin
      wr_dim = reg_wdata[DIM_W-1:0];
      wr_dim_fixed = (wr_dim == DIM_ZERO) ? DIM_ONE : wr_dim;
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pat_lo_r <= RST_PAT_LO;
         pat_hi_r <= RST_PAT_HI;
      end else if (ce && reg_wr) begin
         if (reg_addr == OFS_PAT_LO) begin
            pat_lo_r <= reg_wdata;
         end
         if (reg_addr == OFS_PAT_HI) begin
            pat_hi_r <= reg_wdata[PAT_HI_W-1:0];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         line_ofs_r <= RST_LINE_OFS;
      end else if (ce && reg_wr && reg_addr == OFS_LINE_OFS) begin
         line_ofs_r <= reg_wdata[LINE_OFS_W-1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         width_r <= RST_WIDTH;
      end else if (ce && reg_wr && reg_addr == OFS_WIDTH) begin
         width_r <= wr_dim_fixed;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         height_r <= RST_HEIGHT;
      end else if (ce && reg_wr && reg_addr == OFS_HEIGHT) begin
         height_r <= wr_dim_fixed;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         clip_x_r <= RST_CLIP_X;
      end else if (ce && reg_wr && reg_addr == OFS_CLIP_X) begin
         clip_x_r <= wr_dim;
      end
   end

   // other area modes walk memory linearly, so the offset is held at zero
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         eff_ofs_r <= RST_LINE_OFS;
      end else if (ce) begin
         eff_ofs_r <= (ctrl.area_type_mode == AREA_RECT) ?
                      line_ofs_r : RST_LINE_OFS;
      end
   end

   // flags only report; the engine is not stopped by a bad setting
   always_comb begin
      status_nxt = '0;
      status_nxt[ST_WIDTH_RANGE] = (width_r > MAX_WIDTH);
      status_nxt[ST_HEIGHT_RANGE] = (height_r > MAX_HEIGHT);
      status_nxt[ST_ODD_8BPP] = (ctrl.depth == BGR_BPP8) &&
                                (width_r[0] || dst_x[0]);
      status_nxt[ST_EXPAND_MIN] =
         (ctrl.operation_select_field == OP_MOVE) &&
         ctrl.colour_expand_select && (width_r < MIN_EXPAND_WIDTH);
      status_nxt[ST_PAT_ACTIVE] = pattern_valid;
      status_nxt[ST_ROP_ACTIVE] = rop_pattern_valid;
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         status_r <= '0;
      end else if (ce) begin
         status_r <= status_nxt;
      end
   end

   // unmapped offsets and unused upper bits read as zero
   always_comb begin
      rdata_nxt = 16'h0000;
      unique case (reg_addr)
         OFS_PAT_LO: rdata_nxt = pat_lo_r;
         OFS_PAT_HI: rdata_nxt = 16'({pat_hi_r});
         OFS_LINE_OFS: rdata_nxt = 16'({line_ofs_r});
         OFS_WIDTH: rdata_nxt = 16'({width_r});
         OFS_HEIGHT: rdata_nxt = 16'({height_r});
         OFS_CLIP_X: rdata_nxt = 16'({clip_x_r});
         OFS_STATUS: rdata_nxt = 16'({status_r});
         default: rdata_nxt = 16'h0000;
      endcase
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         reg_rdata <= 16'h0000;
      end else if (ce) begin
         reg_rdata <= reg_rd ? rdata_nxt : 16'h0000;
      end
   end

   bgr_pattern_split u_split (
      .clock(clock),
      .ce(ce),
      .sys_rst(sys_rst),
      .start_addr(pat_start),
      .ctrl(ctrl),
      .pattern(pattern),
      .pattern_valid(pattern_valid),
      .rop_pattern_addr(rop_pattern_addr),
      .rop_pattern_valid(rop_pattern_valid)
   );

   // one line offset serves source, destination and clip
   bgr_window_addr u_src (
      .clock(clock),
      .ce(ce),
      .sys_rst(sys_rst),
      .base(src_base),
      .pos_x(src_x),
      .pos_y(src_y),
      .line_ofs(eff_ofs_r),
      .depth(ctrl.depth),
      .start_addr(src_start_addr)
   );

   bgr_window_addr u_dst (
      .clock(clock),
      .ce(ce),
      .sys_rst(sys_rst),
      .base(dst_base),
      .pos_x(dst_x),
      .pos_y(dst_y),
      .line_ofs(eff_ofs_r),
      .depth(ctrl.depth),
      .start_addr(dst_start_addr)
   );

   bgr_window_addr u_clip (
      .clock(clock),
      .ce(ce),
      .sys_rst(sys_rst),
      .base(dst_base),
      .pos_x({1'b0, clip_x_r}),
      .pos_y({2'b00, clip_y}),
      .line_ofs(eff_ofs_r),
      .depth(ctrl.depth),
      .start_addr(clip_start_addr)
   );

   assign eff_line_offset = eff_ofs_r;
   assign op_width = width_r;
   assign op_height = height_r;
   assign clip_x_start = clip_x_r;
   assign param_status = status_r;

endmodule
`default_nettype wire

// File: bgr_regs_sva.sv
// checker for the blit geometry register group
// assumes ce is held high and the bind sits in the bench top file
`timescale 1ns/1ps
`default_nettype none
module bgr_regs_sva
   import bgr_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire bgr_ctrl_s ctrl,
   input wire bgr_pattern_s pattern,
   input wire logic pattern_valid,
   input wire logic [PAT_ADDR_W-1:0] rop_pattern_addr,
   input wire logic rop_pattern_valid,
   input wire logic [LINE_OFS_W-1:0] eff_line_offset,
   input wire logic [DIM_W-1:0] op_width,
   input wire logic [DIM_W-1:0] op_height
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   logic wr_w;
   logic wr_h;
   assign wr_w = reg_wr && reg_addr == OFS_WIDTH;
   assign wr_h = reg_wr && reg_addr == OFS_HEIGHT;
   // expected split, built apart from the design's own logic
   function automatic bgr_pattern_s split(input logic [26:0] a,
                                          input bgr_depth_e d);
      case (d)
         BGR_BPP8: return {a[26:7], 7'h00, a[5:3], 2'h0, a[2:0]};
         BGR_BPP16: return {a[26:8], 8'h00, a[6:4], 1'b0, a[3:1], 1'b0};
         default: return {a[26:9], 9'h000, a[7:5], a[4:2], 2'h0};
      endcase
   endfunction
   a_width_zero_one:
      assert property (wr_w && reg_wdata[10:0] == DIM_ZERO |=> op_width == DIM_ONE)
      else $error("zero width not stored as one");
   a_width_store:
      assert property (wr_w && reg_wdata[10:0] != DIM_ZERO
         |=> op_width == $past(reg_wdata[10:0])) else $error("width lost");
   a_height_zero_one:
      assert property (wr_h && reg_wdata[10:0] == DIM_ZERO |=> op_height == DIM_ONE)
      else $error("zero height not stored as one");
   a_height_store:
      assert property (wr_h && reg_wdata[10:0] != DIM_ZERO
         |=> op_height == $past(reg_wdata[10:0])) else $error("height lost");
   a_width_readback:
      assert property (reg_rd && reg_addr == OFS_WIDTH
         |=> reg_rdata == {5'h00, $past(op_width)}) else $error("bad read");
   a_fill_valid:
      assert property (1'b1 |=> pattern_valid ==
         ($past(ctrl.operation_select_field) == OP_PATTERN_FILL_TRANSP))
      else $error("fill flag wrong");
   a_rop_valid:
      assert property (1'b1 |=> rop_pattern_valid == $past(ctrl.raster_op_enable))
      else $error("raster flag wrong");
   a_area_rect:
      assert property (ctrl.area_type_mode != AREA_RECT
         |=> eff_line_offset == 13'h0000) else $error("offset not ignored");
   a_pattern_split:
      assert property (ctrl.operation_select_field == OP_PATTERN_FILL_TRANSP
         |=> pattern == split(rop_pattern_addr, $past(ctrl.depth)))
      else $error("pattern split wrong");
   c_zero_width: cover property (wr_w && reg_wdata[10:0] == DIM_ZERO);
   c_fill: cover property (pattern_valid);
   c_rop: cover property (rop_pattern_valid && pattern_valid);
endmodule
`default_nettype wire

// File: bgr_host_model.sv
// host software model: one-cycle write and read strobes
// assumes one rising-edge clock shared with the register group
`timescale 1ns/1ps
`default_nettype none
module bgr_host_model
   import bgr_pkg::*;
(
   input wire logic clock,
   output var logic [15:0] reg_addr,
   output var logic [15:0] reg_wdata,
   output var logic reg_wr,
   output var logic reg_rd,
   input wire logic [15:0] reg_rdata
);
   initial begin
      reg_addr = 16'h0000;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // released lines show the inverse so stale values never pass
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1 d = reg_rdata;
   endtask
endmodule
`default_nettype wire

// File: test_blit_geometry_registers.sv
// bench for the blit geometry register group
// assumes ce stays high; host model drives the register port
`timescale 1ns/1ps
`default_nettype none
module test_blit_geometry_registers;
   import bgr_pkg::*;
   localparam logic [15:0] OFS_T [7] = '{OFS_PAT_LO, OFS_PAT_HI,
      OFS_LINE_OFS, OFS_WIDTH, OFS_HEIGHT, OFS_CLIP_X, 16'h1832};
   localparam logic [15:0] RST_T [7] = '{16'h0000, 16'h0000, 16'h0000,
      16'h0001, 16'h0001, 16'h0000, 16'h0000};
   localparam logic [15:0] ONE_T [7] = '{16'hffff, 16'h07ff, 16'h1fff,
      16'h07ff, 16'h07ff, 16'h07ff, 16'h0000};
   localparam logic [34:0] PAT_T [3] = '{{27'h2a5a580, 3'h6, 5'h06},
      {27'h2a5a500, 3'h3, 5'h06}, {27'h2a5a400, 3'h5, 5'h14}};
   logic clock;
   logic sys_rst;
   logic [15:0] reg_addr;
   logic [15:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [15:0] reg_rdata;
   bgr_ctrl_s ctrl;
   logic [26:0] src_base;
   logic [26:0] dst_base;
   logic [11:0] src_x;
   logic [11:0] src_y;
   logic [11:0] dst_x;
   logic [11:0] dst_y;
   logic [9:0] clip_y;
   bgr_pattern_s pattern;
   logic pattern_valid;
   logic [26:0] rop_pattern_addr;
   logic rop_pattern_valid;
   logic [12:0] eff_line_offset;
   logic [10:0] op_width;
   logic [10:0] op_height;
   logic [26:0] src_start_addr;
   logic [26:0] dst_start_addr;
   logic [26:0] clip_start_addr;
   logic [10:0] clip_x_start;
   logic [5:0] param_status;
   int n_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   bgr_regs bgr_regs_i (.clock(clock), .ce(1'b1), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ctrl(ctrl),
      .src_base(src_base), .src_x(src_x), .src_y(src_y),
      .dst_base(dst_base), .dst_x(dst_x), .dst_y(dst_y), .clip_y(clip_y),
      .pattern(pattern), .pattern_valid(pattern_valid),
      .rop_pattern_addr(rop_pattern_addr),
      .rop_pattern_valid(rop_pattern_valid),
      .eff_line_offset(eff_line_offset), .op_width(op_width),
      .op_height(op_height), .clip_x_start(clip_x_start),
      .src_start_addr(src_start_addr), .dst_start_addr(dst_start_addr),
      .clip_start_addr(clip_start_addr), .param_status(param_status));
   bgr_host_model bgr_host_model_i (.clock(clock), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   task automatic test_done();
      $display("compares %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [34:0] g, input logic [34:0] e);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
      logic [15:0] d;
      bgr_host_model_i.rd(a, d);
      chk({19'h0, d}, {19'h0, e});
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         test_done();
      end
   end
   initial begin
      sys_rst = 1'b1;
      ctrl = '0;
      src_base = 27'h100;
      src_x = 12'h003;
      src_y = 12'h002;
      dst_base = 27'h1000;
      dst_x = 12'hffe;
      dst_y = 12'h001;
      clip_y = 10'h002;
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      for (int i = 0; i < 7; i++) rd_chk(OFS_T[i], RST_T[i]);
      for (int i = 0; i < 7; i++) bgr_host_model_i.wr(OFS_T[i], 16'hffff);
      for (int i = 0; i < 7; i++) rd_chk(OFS_T[i], ONE_T[i]);
      // upper bits set but field zero still counts as zero
      bgr_host_model_i.wr(OFS_WIDTH, 16'hf800);
      bgr_host_model_i.wr(OFS_HEIGHT, 16'hf800);
      rd_chk(OFS_WIDTH, 16'h0001);
      rd_chk(OFS_HEIGHT, 16'h0001);
      bgr_host_model_i.wr(OFS_WIDTH, 16'h0500);
      bgr_host_model_i.wr(OFS_HEIGHT, 16'h0400);
      rd_chk(OFS_WIDTH, 16'h0500);
      chk({24'h0, op_height}, {24'h0, MAX_HEIGHT});
      bgr_host_model_i.wr(OFS_PAT_LO, 16'ha5b6);
      bgr_host_model_i.wr(OFS_PAT_HI, 16'h02a5);
      for (int i = 0; i < 3; i++) begin
         ctrl <= '{OP_PATTERN_FILL_TRANSP, 1'b1, 1'b0, AREA_RECT,
                   bgr_depth_e'(i)};
         repeat (2) @(posedge clock);
         #1 chk(pattern, PAT_T[i]);
         chk({8'h00, rop_pattern_addr}, 35'h2a5a5b6);
         chk({33'h0, rop_pattern_valid, pattern_valid}, 35'h3);
      end
      rd_chk(OFS_STATUS, 16'h0030);
      // expanding move at 8 bpp with an even width of eight
      ctrl <= '{OP_MOVE, 1'b0, 1'b1, AREA_RECT, BGR_BPP8};
      bgr_host_model_i.wr(OFS_WIDTH, 16'h0008);
      chk({33'h0, rop_pattern_valid, pattern_valid}, 35'h0);
      @(posedge clock);
      #1 chk({29'h0, param_status}, 35'h0);
      ctrl <= '{OP_MOVE, 1'b0, 1'b0, AREA_RECT, BGR_BPP16};
      bgr_host_model_i.wr(OFS_LINE_OFS, 16'h0040);
      bgr_host_model_i.wr(OFS_CLIP_X, 16'h0005);
      repeat (3) @(posedge clock);
      #1 chk({22'h0, eff_line_offset}, 35'h40);
      chk({8'h0, src_start_addr}, 35'h186);
      chk({8'h0, dst_start_addr}, 35'h103c);
      chk({8'h0, clip_start_addr}, 35'h108a);
      chk({24'h0, clip_x_start}, 35'h5);
      ctrl.area_type_mode <= 2'h1;
      repeat (3) @(posedge clock);
      #1 chk({22'h0, eff_line_offset}, 35'h0);
      chk({8'h0, src_start_addr}, 35'h106);
      test_done();
   end
endmodule
bind bgr_regs bgr_regs_sva bgr_regs_sva_i (.clock(clock),
   .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ctrl(ctrl),
   .pattern(pattern), .pattern_valid(pattern_valid),
   .rop_pattern_addr(rop_pattern_addr),
   .rop_pattern_valid(rop_pattern_valid),
   .eff_line_offset(eff_line_offset), .op_width(op_width),
   .op_height(op_height));
`default_nettype wire
